/* design/spc_map.svh */
// Purpose: offsets, field positions, reset values and pin class masks for standby pin control
// Assumes: 8-bit register port, 8 pins
// Notes:   definitions only
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// register offsets
`define SPC_OFS_CTRL      8'h00
`define SPC_OFS_STATUS    8'h04
`define SPC_OFS_MASK      8'h08
`define SPC_OFS_STATE     8'h0C
`define SPC_OFS_EXTINT_EN 8'h10
`define SPC_OFS_CMP_EN    8'h14

// standby_control_reg fields
`define SPC_CTRL_HOLD_BIT  0
`define SPC_CTRL_CMD_LO    1
`define SPC_CTRL_CMD_HI    2
`define SPC_CTRL_BUSWK_BIT 3

// standby entry commands in the command field
`define SPC_CMD_NONE  2'h0
`define SPC_CMD_SLEEP 2'h1
`define SPC_CMD_STOP  2'h2
`define SPC_CMD_WATCH 2'h3

// status event bits
`define SPC_EV_ENTER   0
`define SPC_EV_WAKE    1
`define SPC_EV_BUSWAKE 2

// reset values
`define SPC_RST_BYTE 8'h00
`define SPC_RST_OE_N 8'hFF

// pin classes
`define SPC_EXTINT_MASK  8'h3F
`define SPC_CMP_IN_MASK  8'h1B
`define SPC_CMP_OUT_MASK 8'h24
`define SPC_SCL_PIN      6
`define SPC_SDA_PIN      7

`endif

/* design/spc_pkg.sv */
// Purpose: shared types for standby pin control
// Assumes: 8 pins
// Notes:   constants live in spc_map.svh
package spc_pkg;

  typedef enum logic [1:0] {
    SPC_RUN,
    SPC_SLEEP,
    SPC_STOP,
    SPC_WATCH
  } spc_mode_t;

  // per-pin settings from the port and peripheral logic
  typedef struct packed {
    logic [7:0] port_out;
    logic [7:0] dir;
    logic [7:0] func_sel;
    logic [7:0] periph_out;
    logic [7:0] periph_oe;
    logic [7:0] pull_en;
  } spc_pin_cfg_t;

  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spc_bus_req_t;

endpackage

/* design/spc_standby_pins.sv */
// Purpose: per-pin drive and input gating across run, sleep, stop, watch and reset
// Assumes: 10 MHz mclk_in; pad levels arrive asynchronously; pin settings from same clock
// Notes:   registers over a plain strobe port, read data one cycle after the read strobe
//
// What this block does
// (RL1) Run and sleep: pins behave as port or peripheral, unchanged.
// (RL2) Hold select 0 in stop/watch: outputs keep previous state, input blocked.
// (RL3) Hold select 1 in stop/watch: outputs high impedance, input blocked.
// (RL4) Blocked input: internal logic no longer sees the pad level.
// (RL5) Hold select is one bit of the standby control register.
// (RL6) Reset: pins high impedance, input gate on but function inactive.
// (RL7) Pull-up setting stays effective in high impedance standby.
// (RL8) External interrupt inputs stay live in standby when enabled.
// (RL9) Comparator inputs still reach comparator in standby when its interrupt enabled.
// (RL10) Comparator output pins keep working through stop and watch.
// (RL11) Two-wire bus activity wakes stop/watch when bus wake enabled.
// (RL12) Standby states apply to pins set as general-purpose port.
// (RL13) Forced high impedance holds internal input low against leakage.
// (RL14) Wake returns pins to drive and gating of their settings.
// (RL15) Hold select sampled at standby entry, used for whole standby.
`timescale 1ns/100ps
`default_nettype none
`include "spc_map.svh"

module spc_standby_pins
  import spc_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         reset_n_in,
  input  wire spc_bus_req_t bus_in,
  output logic [7:0]        rdata_out,
  input  wire spc_pin_cfg_t cfg_in,
  input  wire logic         wake_req_in,
  input  wire logic [7:0]   pad_in,
  output logic [7:0]        pad_out,
  output logic [7:0]        pad_oe_n_out,
  output logic [7:0]        pull_en_out,
  output logic [7:0]        core_in_out,
  output logic [7:0]        ext_int_in_out,
  output logic [7:0]        cmp_pass_out,
  output logic [1:0]        mode_out,
  output logic              irq_out
);

  // shared helper: pin value the settings ask for
  function automatic logic [7:0] pick(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] b);
    pick = (sel & a) | (~sel & b);
  endfunction

  spc_mode_t  state_reg;
  logic       hold_sel_reg;
  logic       hold_lat_reg;
  logic       bus_wake_en_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [7:0] ext_en_reg;
  logic [7:0] cmp_en_reg;
  logic [7:0] pad_s1_reg;
  logic [7:0] pad_s2_reg;
  logic [7:0] pad_prev_reg;
  logic       func_live_reg;
  logic [7:0] rdata_reg;
  logic [7:0] pad_out_reg;
  logic [7:0] pad_oe_n_reg;
  logic [7:0] pull_reg;
  logic [7:0] core_in_reg;
  logic [7:0] ext_in_reg;
  logic [7:0] cmp_pass_reg;
  logic       irq_reg;

  logic       standby;
  logic       hiz;
  logic [7:0] norm_out;
  logic [7:0] norm_oe;
  logic [1:0] cmd;
  logic       wr_ctrl;
  logic       ext_edge;
  logic       scl_fall;
  logic       sda_fall;
  logic       bus_wake;
  logic       wake;
  logic       enter;
  logic [2:0] ev_set;

  // pad synchroniser, second stage is the only reader of the first
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_s1_reg   <= `SPC_RST_BYTE;
      pad_s2_reg   <= `SPC_RST_BYTE;
      pad_prev_reg <= `SPC_RST_BYTE;
    end else begin
      pad_s1_reg   <= pad_in;
      pad_s2_reg   <= pad_s1_reg;
      pad_prev_reg <= pad_s2_reg;
    end
  end

  // decode and wake sources
  assign standby  = (state_reg == SPC_STOP) || (state_reg == SPC_WATCH);
  assign hiz      = standby && hold_lat_reg;
  assign norm_out = pick(cfg_in.func_sel, cfg_in.periph_out, cfg_in.port_out);
  assign norm_oe  = pick(cfg_in.func_sel, cfg_in.periph_oe, cfg_in.dir);
  assign wr_ctrl  = bus_in.wr && (bus_in.addr == `SPC_OFS_CTRL);
  assign cmd      = bus_in.wdata[`SPC_CTRL_CMD_HI:`SPC_CTRL_CMD_LO];
  assign enter    = wr_ctrl && (state_reg == SPC_RUN) && (cmd != `SPC_CMD_NONE);
  assign ext_edge = |((pad_s2_reg ^ pad_prev_reg) & ext_en_reg & `SPC_EXTINT_MASK);
  assign scl_fall = pad_prev_reg[`SPC_SCL_PIN] && !pad_s2_reg[`SPC_SCL_PIN];
  assign sda_fall = pad_prev_reg[`SPC_SDA_PIN] && !pad_s2_reg[`SPC_SDA_PIN];
  assign bus_wake = standby && bus_wake_en_reg && (scl_fall || sda_fall); // [RL11]
  assign wake     = (state_reg != SPC_RUN) && (wake_req_in || ext_edge || bus_wake);
  assign ev_set   = {bus_wake, wake, enter};

  // mode sequencer; hold select captured only on entry
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg    <= SPC_RUN;
      hold_lat_reg <= 1'b0;
    end else begin
      case (state_reg)
        SPC_RUN: begin
          if (enter) begin
            hold_lat_reg <= hold_sel_reg; // [RL15]
            case (cmd)
              `SPC_CMD_SLEEP: state_reg <= SPC_SLEEP;
              `SPC_CMD_STOP:  state_reg <= SPC_STOP;
              default:        state_reg <= SPC_WATCH;
            endcase
          end
        end
        default: begin
          if (wake) begin
            state_reg <= SPC_RUN; // [RL14]
          end
        end
      endcase
    end
  end

  // software settings; hold select may change in standby but takes effect next entry
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_sel_reg    <= 1'b0;
      bus_wake_en_reg <= 1'b0;
      mask_reg        <= 3'h0;
      ext_en_reg      <= `SPC_RST_BYTE;
      cmp_en_reg      <= `SPC_RST_BYTE;
    end else if (bus_in.wr) begin
      if (bus_in.addr == `SPC_OFS_CTRL) begin
        hold_sel_reg    <= bus_in.wdata[`SPC_CTRL_HOLD_BIT]; // [RL5]
        bus_wake_en_reg <= bus_in.wdata[`SPC_CTRL_BUSWK_BIT];
      end else if (bus_in.addr == `SPC_OFS_MASK) begin
        mask_reg <= bus_in.wdata[2:0];
      end else if (bus_in.addr == `SPC_OFS_EXTINT_EN) begin
        ext_en_reg <= bus_in.wdata;
      end else if (bus_in.addr == `SPC_OFS_CMP_EN) begin
        cmp_en_reg <= bus_in.wdata;
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_reg <= 3'h0;
    end else if (bus_in.wr && (bus_in.addr == `SPC_OFS_STATUS)) begin
      status_reg <= (status_reg & ~bus_in.wdata[2:0]) | ev_set;
    end else begin
      status_reg <= status_reg | ev_set;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // read port, unmapped offsets read zero
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= `SPC_RST_BYTE;
    end else if (!bus_in.rd) begin
      rdata_reg <= `SPC_RST_BYTE;
    end else if (bus_in.addr == `SPC_OFS_CTRL) begin
      rdata_reg <= {4'h0, bus_wake_en_reg, 2'h0, hold_sel_reg};
    end else if (bus_in.addr == `SPC_OFS_STATUS) begin
      rdata_reg <= {5'h00, status_reg};
    end else if (bus_in.addr == `SPC_OFS_MASK) begin
      rdata_reg <= {5'h00, mask_reg};
    end else if (bus_in.addr == `SPC_OFS_STATE) begin
      rdata_reg <= {5'h00, hold_lat_reg, state_reg};
    end else if (bus_in.addr == `SPC_OFS_EXTINT_EN) begin
      rdata_reg <= ext_en_reg;
    end else if (bus_in.addr == `SPC_OFS_CMP_EN) begin
      rdata_reg <= cmp_en_reg;
    end else begin
      rdata_reg <= `SPC_RST_BYTE;
    end
  end

  // pin function stays dead for the first cycle after reset
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      func_live_reg <= 1'b0; // [RL6]
    end else begin
      func_live_reg <= 1'b1;
    end
  end

  // output level: frozen in standby except comparator outputs
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_out_reg <= `SPC_RST_BYTE;
    end else if (!standby) begin
      pad_out_reg <= norm_out; // [RL1] [RL12] [RL14]
    end else begin
      pad_out_reg <= pick(`SPC_CMP_OUT_MASK, norm_out, pad_out_reg); // [RL2] [RL10]
    end
  end

  // output enable, low while driving; reset floats every pin
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_oe_n_reg <= `SPC_RST_OE_N; // [RL6]
    end else if (!func_live_reg || !standby) begin
      pad_oe_n_reg <= func_live_reg ? ~norm_oe : `SPC_RST_OE_N; // [RL1] [RL14]
    end else if (hiz) begin
      pad_oe_n_reg <= pick(`SPC_CMP_OUT_MASK, ~norm_oe, `SPC_RST_OE_N); // [RL3] [RL10]
    end else begin
      pad_oe_n_reg <= pick(`SPC_CMP_OUT_MASK, ~norm_oe, pad_oe_n_reg); // [RL2]
    end
  end

  // pull-up follows its setting in every mode, avoids floating hi-z pads
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pull_reg <= `SPC_RST_BYTE;
    end else begin
      pull_reg <= cfg_in.pull_en; // [RL7]
    end
  end

  // core input gate: blocked in standby, forced low under hi-z
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_in_reg <= `SPC_RST_BYTE;
    end else if (!standby) begin
      core_in_reg <= func_live_reg ? pad_s2_reg : `SPC_RST_BYTE; // [RL1] [RL6]
    end else if (hiz) begin
      core_in_reg <= `SPC_RST_BYTE; // [RL13] [RL3] [RL4]
    end else begin
      core_in_reg <= core_in_reg; // [RL2] [RL4]
    end
  end

  // external interrupt path survives standby only where enabled
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_in_reg <= `SPC_RST_BYTE;
    end else if (standby) begin
      ext_in_reg <= pad_s2_reg & ext_en_reg & `SPC_EXTINT_MASK; // [RL8]
    end else begin
      ext_in_reg <= pad_s2_reg & `SPC_EXTINT_MASK;
    end
  end

  // analog pass to comparators; in standby only with comparator irq enabled
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_pass_reg <= `SPC_RST_BYTE;
    end else if (standby) begin
      cmp_pass_reg <= cmp_en_reg & `SPC_CMP_IN_MASK; // [RL9]
    end else begin
      cmp_pass_reg <= `SPC_CMP_IN_MASK;
    end
  end

  assign rdata_out      = rdata_reg;
  assign pad_out        = pad_out_reg;
  assign pad_oe_n_out   = pad_oe_n_reg;
  assign pull_en_out    = pull_reg;
  assign core_in_out    = core_in_reg;
  assign ext_int_in_out = ext_in_reg;
  assign cmp_pass_out   = cmp_pass_reg;
  assign mode_out       = state_reg;
  assign irq_out        = irq_reg;

  // checks beside the logic
  property p_run_follows;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (state_reg == SPC_RUN && func_live_reg) |=> (pad_oe_n_reg == ~$past(norm_oe)) && (pad_out_reg == $past(norm_out));
  endproperty
  a_run_follows: assert property (p_run_follows) else $error("run pins do not follow settings"); // [RL1]

  property p_hold_keeps;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (standby && !hold_lat_reg) |=> (((pad_out_reg ^ $past(pad_out_reg)) & ~`SPC_CMP_OUT_MASK) == 8'h00);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("held pin level changed"); // [RL2]

  property p_hiz_float;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (standby && hold_lat_reg) |=> ((pad_oe_n_reg | `SPC_CMP_OUT_MASK) == 8'hFF);
  endproperty
  a_hiz_float: assert property (p_hiz_float) else $error("pin driven in hi-z standby"); // [RL3]

  property p_hiz_low;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (standby && hold_lat_reg) |=> (core_in_reg == 8'h00);
  endproperty
  a_hiz_low: assert property (p_hiz_low) else $error("open input not held low"); // [RL13]

  property p_blocked;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (standby && !hold_lat_reg) |=> $stable(core_in_reg);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked input still moves"); // [RL4]

  property p_pull;
    @(posedge mclk_in) disable iff (!reset_n_in)
      standby |=> (pull_reg == $past(cfg_in.pull_en));
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up lost in standby"); // [RL7]

  property p_ext_live;
    @(posedge mclk_in) disable iff (!reset_n_in)
      standby |=> (ext_in_reg == ($past(pad_s2_reg) & $past(ext_en_reg) & `SPC_EXTINT_MASK));
  endproperty
  a_ext_live: assert property (p_ext_live) else $error("ext interrupt path wrong in standby"); // [RL8]

  property p_cmp_pass;
    @(posedge mclk_in) disable iff (!reset_n_in)
      standby |=> (cmp_pass_reg == ($past(cmp_en_reg) & `SPC_CMP_IN_MASK));
  endproperty
  a_cmp_pass: assert property (p_cmp_pass) else $error("comparator input gating wrong"); // [RL9]

  property p_cmp_out;
    @(posedge mclk_in) disable iff (!reset_n_in)
      standby |=> (((pad_out_reg ^ $past(norm_out)) & `SPC_CMP_OUT_MASK) == 8'h00);
  endproperty
  a_cmp_out: assert property (p_cmp_out) else $error("comparator output frozen"); // [RL10]

  property p_bus_wake;
    @(posedge mclk_in) disable iff (!reset_n_in)
      bus_wake |=> (state_reg == SPC_RUN) ##1 status_reg[`SPC_EV_BUSWAKE];
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus activity did not wake"); // [RL11]

  property p_hold_steady;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (standby ##1 standby) |-> $stable(hold_lat_reg);
  endproperty
  a_hold_steady: assert property (p_hold_steady) else $error("hold select moved in standby"); // [RL15]

  property p_reset_float;
    @(posedge mclk_in) disable iff (!reset_n_in)
      !func_live_reg |=> (pad_oe_n_reg == 8'hFF) && (core_in_reg == 8'h00);
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("pins active during reset"); // [RL6]

endmodule
`default_nettype wire

/* verification/spc_standby_pins_tb.sv */
// Purpose: self-checking bench for standby pin control, register port plus pin behaviour per mode
// Assumes: 10 MHz mclk_in; pad_in two-flop synchronised inside, so input checks wait a few cycles
// Notes:   checks run after each edge has settled; ext int kept off unless under test, bus wake stays on from its test to the second reset
`timescale 1ns/100ps
`default_nettype none
`include "spc_map.svh"

module testbench
  import spc_pkg::*;
;

  logic         mclk_in;
  logic         reset_n_in;
  logic         wake_req_in;
  spc_bus_req_t bus_in;
  spc_pin_cfg_t cfg_in;
  logic [7:0]   pad_in;
  logic [7:0]   rdata_out;
  logic [7:0]   pad_out;
  logic [7:0]   pad_oe_n_out;
  logic [7:0]   pull_en_out;
  logic [7:0]   core_in_out;
  logic [7:0]   ext_int_in_out;
  logic [7:0]   cmp_pass_out;
  logic [1:0]   mode_out;
  logic         irq_out;
  int           n_errors;
  int           n_tests;
  logic [7:0]   v;

  spc_standby_pins uut (
    .mclk_in        (mclk_in),
    .reset_n_in     (reset_n_in),
    .bus_in         (bus_in),
    .rdata_out      (rdata_out),
    .cfg_in         (cfg_in),
    .wake_req_in    (wake_req_in),
    .pad_in         (pad_in),
    .pad_out        (pad_out),
    .pad_oe_n_out   (pad_oe_n_out),
    .pull_en_out    (pull_en_out),
    .core_in_out    (core_in_out),
    .ext_int_in_out (ext_int_in_out),
    .cmp_pass_out   (cmp_pass_out),
    .mode_out       (mode_out),
    .irq_out        (irq_out)
  );

  // 100 ns period
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe; the next call waits an edge, so strobes never double-drive
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus_in <= '0;
  endtask

  // read data only stands in the cycle after the strobe, so sample 10 ns into that cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_in <= '0;
    #10 d = rdata_out;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
    #10;
  endtask

  // bounded wait for the mode to reach m
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 20 && mode_out !== m; i++) begin
      @(posedge mclk_in);
      #10;
    end
    chk("mode", {6'h00, m}, {6'h00, mode_out});
  endtask

  task automatic wake_up();
    @(posedge mclk_in);
    wake_req_in <= 1'b1;
    wait_mode(2'h0);
    @(posedge mclk_in);
    wake_req_in <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog at 20000 cycles; the sequence needs well under 2000
  initial begin
    #2_000_000;
    n_errors++;
    end_sim();
  end

  initial begin
    reset_n_in  = 1'b0;
    wake_req_in = 1'b0;
    bus_in      = '0;
    pad_in      = 8'h3C;
    // pins 0..3 peripheral, pin 2 peripheral not driving
    cfg_in      = '{port_out: 8'hA5, dir: 8'hFF, func_sel: 8'h0F, periph_out: 8'h0A,
                    periph_oe: 8'h0B, pull_en: 8'h30};
    n_errors    = 0;
    n_tests     = 0;
    repeat (10) @(posedge mclk_in);
    #10;
    chk("reset oe_n", `SPC_RST_OE_N, pad_oe_n_out);
    chk("reset core_in", 8'h00, core_in_out);
    reset_n_in <= 1'b1;
    // first edge after release: pins still float, function not yet live
    @(posedge mclk_in);
    #10;
    chk("first edge oe_n", `SPC_RST_OE_N, pad_oe_n_out);
    rd_reg(`SPC_OFS_CTRL, v);
    chk("ctrl reset", `SPC_RST_BYTE, v);
    $display("test reset done");

    // run: port and peripheral paths as configured
    settle(5);
    chk("run oe_n", 8'h04, pad_oe_n_out);
    chk("run pad_out", 8'hAA, pad_out);
    chk("run core_in", 8'h3C, core_in_out);
    chk("run pull", 8'h30, pull_en_out);

    // sleep blocks nothing
    wr_reg(`SPC_OFS_CTRL, 8'h02);
    pad_in <= 8'h5A;
    settle(5);
    chk("sleep mode", 8'h01, {6'h00, mode_out});
    chk("sleep oe_n", 8'h04, pad_oe_n_out);
    chk("sleep core_in", 8'h5A, core_in_out);
    wake_up();
    $display("test sleep done");

    // stop with hold select 0: outputs kept, input frozen
    wr_reg(`SPC_OFS_CTRL, 8'h04);
    settle(2);
    pad_in <= 8'h81;
    settle(5);
    chk("hold oe_n", 8'h04, pad_oe_n_out);
    chk("hold pad_out", 8'hAA, pad_out);
    chk("hold core_in", 8'h5A, core_in_out);
    chk("hold cmp pass", 8'h00, cmp_pass_out);
    rd_reg(`SPC_OFS_STATE, v);
    chk("hold state", 8'h02, v);
    wake_up();
    settle(5);
    chk("wake core_in", 8'h81, core_in_out);
    $display("test stop hold done");

    // watch with hold select 1: hi-Z except comparator outputs
    wr_reg(`SPC_OFS_CMP_EN, 8'h0A);
    wr_reg(`SPC_OFS_CTRL, 8'h01);
    wr_reg(`SPC_OFS_CTRL, 8'h07);
    settle(3);
    chk("hiz oe_n", 8'hDF, pad_oe_n_out);
    chk("hiz core_in", 8'h00, core_in_out);
    chk("hiz pull", 8'h30, pull_en_out);
    chk("hiz cmp pass", 8'h0A, cmp_pass_out);
    wr_reg(`SPC_OFS_CTRL, 8'h04);
    rd_reg(`SPC_OFS_STATE, v);
    chk("hiz state", 8'h07, v);
    wake_up();
    settle(2);
    chk("wake oe_n", 8'h04, pad_oe_n_out);
    $display("test watch hiz done");

    // external interrupt pin wakes stop when enabled
    wr_reg(`SPC_OFS_STATUS, 8'h07);
    wr_reg(`SPC_OFS_EXTINT_EN, 8'h01);
    wr_reg(`SPC_OFS_CTRL, 8'h00);
    wr_reg(`SPC_OFS_CTRL, 8'h04);
    settle(2);
    chk("ext live", 8'h01, ext_int_in_out);
    pad_in <= 8'h80;
    wait_mode(2'h0);
    rd_reg(`SPC_OFS_STATUS, v);
    chk("ext wake status", 8'h03, v);
    settle(4);
    chk("ext path", 8'h00, ext_int_in_out);
    $display("test ext wake done");

    // bus clock falling edge wakes stop when bus wake enabled
    wr_reg(`SPC_OFS_EXTINT_EN, 8'h00);
    wr_reg(`SPC_OFS_STATUS, 8'h07);
    pad_in <= 8'hC0;
    wr_reg(`SPC_OFS_CTRL, 8'h08);
    wr_reg(`SPC_OFS_CTRL, 8'h0C);
    settle(4);
    pad_in <= 8'h80;
    wait_mode(2'h0);
    rd_reg(`SPC_OFS_STATUS, v);
    chk("bus wake status", 8'h04, v & 8'h04);
    $display("test bus wake done");

    // interrupt: masked, unmasked, cleared
    wr_reg(`SPC_OFS_MASK, 8'h00);
    settle(2);
    chk("irq masked", 8'h00, {7'h00, irq_out});
    wr_reg(`SPC_OFS_MASK, 8'h04);
    settle(2);
    chk("irq raised", 8'h01, {7'h00, irq_out});
    wr_reg(`SPC_OFS_STATUS, 8'h04);
    settle(2);
    chk("irq cleared", 8'h00, {7'h00, irq_out});
    wr_reg(8'h20, 8'hFF);
    rd_reg(8'h20, v);
    chk("unmapped", 8'h00, v);
    rd_reg(`SPC_OFS_CTRL, v);
    chk("ctrl readback", 8'h08, v);
    $display("test irq done");

    // second reset in mid-run
    @(posedge mclk_in);
    reset_n_in <= 1'b0;
    settle(2);
    chk("rst2 oe_n", `SPC_RST_OE_N, pad_oe_n_out);
    chk("rst2 pull", 8'h00, pull_en_out);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    #10;
    chk("rst2 first edge oe_n", `SPC_RST_OE_N, pad_oe_n_out);
    settle(1);
    chk("rst2 run oe_n", 8'h04, pad_oe_n_out);
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
